// >>> hw/acc_cmp.sv
/*
 * acc_cmp: compare of a finished result against the compare value.
 * assumes: both values are 12-bit unsigned and stable with the done strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module acc_cmp (
    // operands
    input wire logic [11:0] result,
    input wire logic [11:0] limit,
    // mode and outcome
    input wire logic greater_sel,
    output logic hit
);
    wire below = result < limit;

    // less-than by default, greater-or-equal when selected, see R16
    assign hit = greater_sel ? ~below : below;
endmodule // acc_cmp
`default_nettype wire

// >>> hw/acc_ctrl.sv
/*
 * acc_ctrl: conversion control of a 12-bit successive approximation
 * converter: AHB-Lite register slave, trigger logic, done flag,
 * interrupt, result capture and core power control.
 * assumes: the analog core answers a start pulse with a done strobe
 * and result on clk; the hardware trigger pin is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R01 - sc1 write aborts and restarts unless off; code restarts only with software trigger
// R02 - done flag never set by bus
// R03 - compare off: every completion sets done
// R04 - compare on: done only on true compare
// R05 - sc1 write or low read clears done
// R06 - done with enable raises interrupt
// R07 - single mode: one conversion per trigger
// R08 - continuous mode: trigger starts repeated conversions
// R09 - 5-bit channel field, refs, reserved code
// R10 - all ones powers off and isolates input
// R11 - all ones stops continuous, no extra conversion
// R12 - single mode idles after each conversion
// R13 - 28 inputs chosen only by channel field
// R14 - active bit tracks start to end/abort
// R15 - trigger select: write or hardware pin
// R16 - compare less-than or greater-equal
// R17 - result held when compare fails
// R18 - core start pulse and done strobe
module acc_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // hardware trigger pin
    input wire logic hardware_trigger_input,
    // converter core
    output acc_pkg::acc_core_req_t core_req,
    input wire acc_pkg::acc_core_rsp_t core_rsp,
    // interrupt
    output logic irq
);
    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic busy_ff, wr_ff, ready_ff;
    logic [7:0] addr_ff;
    logic [31:0] rdata_ff;
    wire take = hsel & htrans[1] & hready;

    // one wait state per transfer so that read data come from a flop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busy_ff <= 1'b0;
            wr_ff <= 1'b0;
            addr_ff <= 8'h00;
            ready_ff <= 1'b1;
        end else begin
            busy_ff <= take;
            ready_ff <= ~take;
            if (take) begin
                wr_ff <= hwrite;
                addr_ff <= {haddr[7:2], 2'b00};
            end
        end
    end

    wire do_wr = busy_ff & wr_ff;
    wire do_rd = busy_ff & ~wr_ff;
    wire wr_sc1 = do_wr & (addr_ff == acc_pkg::OFF_SC1);
    wire wr_sc2 = do_wr & (addr_ff == acc_pkg::OFF_SC2);
    wire wr_cmp = do_wr & (addr_ff == acc_pkg::OFF_CMP_VAL);
    wire wr_sts = do_wr & (addr_ff == acc_pkg::OFF_IRQ_STS);
    wire wr_msk = do_wr & (addr_ff == acc_pkg::OFF_IRQ_MSK);
    wire rd_lo = do_rd & (addr_ff == acc_pkg::OFF_RES_LO);
    wire [4:0] chan_in = hwdata[4:0];

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [4:0] chan_ff;
    logic done_interrupt_enable_ff, cont_ff, trig_ff, cmp_en_ff, cmp_gt_ff;
    logic [11:0] cmp_val_ff;
    logic [1:0] msk_ff;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            chan_ff <= acc_pkg::RST_CHAN;
            done_interrupt_enable_ff <= 1'b0;
            cont_ff <= 1'b0;
            trig_ff <= 1'b0;
            cmp_en_ff <= 1'b0;
            cmp_gt_ff <= 1'b0;
            cmp_val_ff <= acc_pkg::RST_WORD12;
            msk_ff <= acc_pkg::RST_IRQ;
        end else begin
            if (wr_sc1) begin
                // done bit of the written word is dropped, see R02
                chan_ff <= chan_in; // see R09
                done_interrupt_enable_ff <= hwdata[acc_pkg::BIT_DONE_INTERRUPT_ENABLE];
                cont_ff <= hwdata[acc_pkg::BIT_CONT];
            end
            if (wr_sc2) begin
                trig_ff <= hwdata[acc_pkg::BIT_TRIG];
                cmp_en_ff <= hwdata[acc_pkg::BIT_CMP_EN];
                cmp_gt_ff <= hwdata[acc_pkg::BIT_CMP_GT];
            end
            if (wr_cmp)
                cmp_val_ff <= hwdata[11:0];
            if (wr_msk)
                msk_ff <= hwdata[1:0];
        end
    end

    // ----------------------------------------
    // trigger and sequencing
    // ----------------------------------------
    logic hw_rise, hit;
    logic active_ff, run_ff, start_ff, power_ff, iso_ff;
    logic [4:0] core_ch_ff;

    acc_hw_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin(hardware_trigger_input),
        .rise(hw_rise)
    );

    acc_cmp u_cmp (
        .result(core_rsp.result),
        .limit(cmp_val_ff),
        .greater_sel(cmp_gt_ff),
        .hit(hit)
    );

    // a done strobe outside a conversion is stale and ignored, see R18
    wire cmp_done = core_rsp.done & active_ff;
    wire off_now = wr_sc1 & (chan_in == acc_pkg::CH_OFF);
    wire sw_go = wr_sc1 & ~trig_ff & ~off_now; // see R01 R15
    wire hw_go = hw_rise & trig_ff & ~wr_sc1 &
        (chan_ff != acc_pkg::CH_OFF) & ~active_ff; // see R15
    // repeat only while continuous stays on and channel is live
    wire again = cmp_done & run_ff & cont_ff & ~wr_sc1 &
        (chan_ff != acc_pkg::CH_OFF); // see R08 R11
    wire start_now = sw_go | hw_go | again;
    wire [4:0] next_ch = wr_sc1 ? chan_in : chan_ff;
    wire next_cont = wr_sc1 ? hwdata[acc_pkg::BIT_CONT] : cont_ff;
    wire abort = wr_sc1 & active_ff & ~core_rsp.done;
    wire nxt_active = start_now | (active_ff & ~cmp_done & ~wr_sc1);
    // continuous run ends on any sc1 write without restart or on single mode
    wire nxt_run = start_now ? next_cont :
        (run_ff & ~wr_sc1 & ~(cmp_done & ~cont_ff)); // see R07 R11

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            active_ff <= 1'b0;
            run_ff <= 1'b0;
            start_ff <= 1'b0;
            power_ff <= 1'b0;
            iso_ff <= 1'b1;
            core_ch_ff <= acc_pkg::RST_CHAN;
        end else begin
            start_ff <= start_now; // see R18
            active_ff <= nxt_active; // see R14
            run_ff <= nxt_run;
            // power only while converting or armed, see R10 R12
            power_ff <= nxt_active | nxt_run;
            iso_ff <= next_ch == acc_pkg::CH_OFF; // see R10
            core_ch_ff <= next_ch; // see R13
        end
    end

    // one driver for the whole carrier, field order as the package has it
    assign core_req = {start_ff, power_ff, iso_ff, core_ch_ff};

    // ----------------------------------------
    // done flag, result and interrupt
    // ----------------------------------------
    logic done_ff, irq_ff;
    logic [11:0] result_ff;
    logic [1:0] sts_ff;
    wire take_res = cmp_done & (~cmp_en_ff | hit); // see R03 R04 R17
    wire [1:0] sts_set = {abort, take_res};
    wire [1:0] sts_clr = wr_sts ? hwdata[1:0] : 2'b00;
    wire [1:0] nxt_sts = sts_set | (sts_ff & ~sts_clr);
    // a completion wins over a clear in the same cycle
    wire nxt_done = take_res | (done_ff & ~wr_sc1 & ~rd_lo);
    wire nxt_done_interrupt_enable = wr_sc1 ? hwdata[acc_pkg::BIT_DONE_INTERRUPT_ENABLE] : done_interrupt_enable_ff;
    wire [1:0] nxt_msk = wr_msk ? hwdata[1:0] : msk_ff;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            done_ff <= 1'b0;
            result_ff <= acc_pkg::RST_WORD12;
            sts_ff <= acc_pkg::RST_IRQ;
            irq_ff <= 1'b0;
        end else begin
            done_ff <= nxt_done; // see R05
            if (take_res)
                result_ff <= core_rsp.result;
            sts_ff <= nxt_sts;
            // next values keep irq in step with flag, enable and mask
            irq_ff <= (nxt_done & nxt_done_interrupt_enable) |
                (|(nxt_sts & nxt_msk)); // see R06
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    wire [7:0] sc1_rd = {done_ff, done_interrupt_enable_ff, cont_ff, chan_ff};
    wire [7:0] sc2_rd = {active_ff, trig_ff, cmp_en_ff, cmp_gt_ff, 4'h0};
    wire [31:0] rd_mux =
        (addr_ff == acc_pkg::OFF_SC1) ? {24'h00_0000, sc1_rd} :
        (addr_ff == acc_pkg::OFF_SC2) ? {24'h00_0000, sc2_rd} :
        (addr_ff == acc_pkg::OFF_RES_HI) ? {28'h000_0000, result_ff[11:8]} :
        (addr_ff == acc_pkg::OFF_RES_LO) ? {24'h00_0000, result_ff[7:0]} :
        (addr_ff == acc_pkg::OFF_CMP_VAL) ? {20'h0_0000, cmp_val_ff} :
        (addr_ff == acc_pkg::OFF_IRQ_STS) ? {30'h0000_0000, sts_ff} :
        (addr_ff == acc_pkg::OFF_IRQ_MSK) ? {30'h0000_0000, msk_ff} :
        32'h0000_0000;

    // unmapped reads answer zero with OKAY
    always_ff @(posedge clk) begin
        if (!rst_b)
            rdata_ff <= 32'h0000_0000;
        else if (do_rd)
            rdata_ff <= rd_mux;
    end

    assign hrdata = rdata_ff;
    assign hreadyout = ready_ff;
    assign hresp = 1'b0;
    assign irq = irq_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_write_starts: assert property ( // see R01
        @(posedge clk) disable iff (!rst_b)
        wr_sc1 && chan_in != acc_pkg::CH_OFF && !trig_ff |=> start_ff)
        else $error("sc1 write did not start a conversion");

    a_done_bus_ro: assert property ( // see R02
        @(posedge clk) disable iff (!rst_b)
        wr_sc1 && !cmp_done |=> !done_ff)
        else $error("bus write left done flag set");

    a_done_plain: assert property ( // see R03
        @(posedge clk) disable iff (!rst_b)
        cmp_done && !cmp_en_ff |=> done_ff)
        else $error("completion did not set done flag");

    a_done_cmp_miss: assert property ( // see R04
        @(posedge clk) disable iff (!rst_b)
        cmp_done && cmp_en_ff && !hit && !done_ff |=> !done_ff)
        else $error("done set on false compare");

    a_done_rd_clear: assert property ( // see R05
        @(posedge clk) disable iff (!rst_b)
        rd_lo && !cmp_done |=> !done_ff)
        else $error("low result read did not clear done");

    a_irq_raise: assert property ( // see R06
        @(posedge clk) disable iff (!rst_b)
        done_ff && done_interrupt_enable_ff |-> irq_ff)
        else $error("interrupt missing with done and enable");

    a_single_idle: assert property ( // see R07 R12
        @(posedge clk) disable iff (!rst_b)
        cmp_done && !cont_ff && !start_now |=> !active_ff && !power_ff)
        else $error("single conversion did not return to idle");

    a_cont_again: assert property ( // see R08
        @(posedge clk) disable iff (!rst_b)
        cmp_done && run_ff && cont_ff && !wr_sc1 &&
        chan_ff != acc_pkg::CH_OFF |=> start_ff && active_ff)
        else $error("continuous run did not restart");

    a_off_stops: assert property ( // see R10 R11
        @(posedge clk) disable iff (!rst_b)
        off_now |=> !start_ff && !active_ff && iso_ff && !power_ff)
        else $error("all-ones channel did not stop the core");

    a_active_track: assert property ( // see R14
        @(posedge clk) disable iff (!rst_b)
        start_ff |-> active_ff)
        else $error("active bit not set at start");

    a_result_hold: assert property ( // see R17
        @(posedge clk) disable iff (!rst_b)
        cmp_done && cmp_en_ff && !hit |=> $stable(result_ff))
        else $error("result changed on failed compare");

    a_ready_wait: assert property (
        @(posedge clk) disable iff (!rst_b)
        take |=> !ready_ff ##1 ready_ff)
        else $error("bus wait state not exactly one cycle");

    a_hw_refused: assert property ( // see R15
        @(posedge clk) disable iff (!rst_b)
        hw_rise && active_ff && !wr_sc1 && !cmp_done |=> !start_ff)
        else $error("hardware trigger started while active");

    a_abort_flag: assert property ( // see R14
        @(posedge clk) disable iff (!rst_b)
        abort |=> sts_ff[acc_pkg::STS_ABORT])
        else $error("abort event not recorded");

    a_write_trig_wait: assert property ( // see R14
        @(posedge clk) disable iff (!rst_b)
        wr_sc1 && trig_ff |=> !start_ff && !active_ff)
        else $error("write in hardware trigger mode started a conversion");

    a_result_take: assert property ( // see R17
        @(posedge clk) disable iff (!rst_b)
        take_res |=> result_ff == $past(core_rsp.result))
        else $error("result not captured on completion");

    a_irq_status: assert property ( // see R06
        @(posedge clk) disable iff (!rst_b)
        irq_ff == ((done_ff && done_interrupt_enable_ff) || (|(sts_ff & msk_ff))))
        else $error("interrupt level disagrees with flags");

    a_channel_follow: assert property ( // see R09
        @(posedge clk) disable iff (!rst_b)
        wr_sc1 |=> core_ch_ff == $past(chan_in) && chan_ff == $past(chan_in))
        else $error("channel code not passed to the core");

    a_power_level: assert property ( // see R12
        @(posedge clk) disable iff (!rst_b)
        power_ff == (active_ff || run_ff))
        else $error("core powered while idle");

    a_done_no_source: assert property ( // see R02
        @(posedge clk) disable iff (!rst_b)
        !cmp_done && !done_ff |=> !done_ff)
        else $error("done flag set without a completion");
endmodule // acc_ctrl
`default_nettype wire

// >>> hw/acc_hw_sync.sv
/*
 * acc_hw_sync: two-flop synchroniser for the hardware trigger pin and
 * a one-cycle pulse on its rising edge.
 * assumes: the pin is asynchronous to clk and held high for 2+ cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module acc_hw_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pin and pulse
    input wire logic pin,
    output logic rise
);
    logic meta_ff, sync_ff, last_ff;

    // first flop feeds only the second one
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign rise = sync_ff & ~last_ff;
endmodule // acc_hw_sync
`default_nettype wire

// >>> hw/acc_pkg.sv
/*
 * acc_pkg: register offsets, bit positions, reset values and the
 * structs that carry the converter core request and response.
 * assumes: byte addresses on a 32-bit AHB-Lite bus, 4 ns clock.
 */
package acc_pkg;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_SC1 = 8'h00;
    localparam logic [7:0] OFF_SC2 = 8'h04;
    localparam logic [7:0] OFF_RES_HI = 8'h08;
    localparam logic [7:0] OFF_RES_LO = 8'h0C;
    localparam logic [7:0] OFF_CMP_VAL = 8'h10;
    localparam logic [7:0] OFF_IRQ_STS = 8'h14;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h18;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_DONE = 7;
    localparam int BIT_DONE_INTERRUPT_ENABLE = 6;
    localparam int BIT_CONT = 5;
    localparam int BIT_ACTIVE = 7;
    localparam int BIT_TRIG = 6;
    localparam int BIT_CMP_EN = 5;
    localparam int BIT_CMP_GT = 4;
    localparam int STS_DONE = 0;
    localparam int STS_ABORT = 1;
    // ----------------------------------------
    // channel codes and reset values
    // ----------------------------------------
    localparam logic [4:0] CH_OFF = 5'h1F;
    localparam logic [4:0] CH_RSVD = 5'h1C;
    localparam logic [4:0] CH_REFH = 5'h1D;
    localparam logic [4:0] CH_REFL = 5'h1E;
    localparam logic [4:0] RST_CHAN = 5'h1F;
    localparam logic [11:0] RST_WORD12 = 12'h000;
    localparam logic [1:0] RST_IRQ = 2'h0;
    // ----------------------------------------
    // core carriers
    // ----------------------------------------
    typedef struct packed {
        logic start;
        logic power;
        logic isolate;
        logic [4:0] channel;
    } acc_core_req_t;
    typedef struct packed {
        logic done;
        logic [11:0] result;
    } acc_core_rsp_t;
endpackage

// >>> tb/acc_core_model.sv
/*
 * acc_core_model: behavioural analog core behind acc_ctrl.
 * assumes: the bench sets latency and result before each start.
 */
`timescale 1ns/1ps
`default_nettype none
module acc_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // bench control
    input wire logic [11:0] res_val,
    input wire logic [7:0] lat,
    // core link
    input wire acc_pkg::acc_core_req_t core_req,
    output var acc_pkg::acc_core_rsp_t core_rsp
);
    logic busy_ff;
    logic done_ff;
    logic [7:0] cnt_ff;
    logic [11:0] res_ff;
    // result is valid only with done; inverse elsewhere catches late use
    assign core_rsp = {done_ff, done_ff ? res_ff : ~res_ff};
    always_ff @(posedge clk) begin
        done_ff <= 1'b0;
        if (!rst_b) begin
            busy_ff <= 1'b0;
            cnt_ff <= 8'h00;
            res_ff <= 12'h000;
        end else if (core_req.start) begin
            busy_ff <= 1'b1;
            cnt_ff <= lat;
        end else if (busy_ff && !core_req.power) begin
            busy_ff <= 1'b0;
        end else if (busy_ff && cnt_ff == 8'h00) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            res_ff <= res_val;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end
endmodule // acc_core_model
`default_nettype wire

// >>> tb/acc_ctrl_tb.sv
/*
 * acc_ctrl_tb: register-level tests of acc_ctrl over AHB-Lite.
 * assumes: acc_core_model answers each start after lat+1 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_tb;
    logic clk, rst_b, hsel, hwrite, pin;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, rd;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, irq;
    acc_pkg::acc_core_req_t core_req;
    acc_pkg::acc_core_rsp_t core_rsp;
    logic [11:0] res_val;
    logic [7:0] lat;
    int fails, cmp_count, cyc, starts, snap, i;
    // ----------------------------------------
    // clock, instances, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    acc_ctrl acc_ctrl_inst (.clk(clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .hardware_trigger_input(pin), .core_req(core_req),
        .core_rsp(core_rsp), .irq(irq));
    acc_core_model acc_core_model_inst (.clk(clk), .rst_b(rst_b),
        .res_val(res_val), .lat(lat), .core_req(core_req),
        .core_rsp(core_rsp));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (core_req.start === 1'b1) starts <= starts + 1;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string n);
        xfer(1'b0, a, 32'h0000_0000);
        chk(n, e, rd);
    endtask
    // conversions wait for the core done strobe, bounded by a fixed count of 300 cycles
    task automatic wait_conv();
        int n;
        n = 0;
        while (core_rsp.done !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) begin
            fails++;
            $display("wrong value conversion expected done seen timeout");
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_b = 1'b0; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0;
        haddr = 32'h0000_0000; hwdata = 32'h0000_0000; pin = 1'b0;
        res_val = 12'hABC; lat = 8'h0A;
        fails = 0; cmp_count = 0; cyc = 0; starts = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rchk(acc_pkg::OFF_SC1, 32'h0000_001F, "sc1 reset");
        chk("isolate", 32'h1, core_req.isolate);
        rchk(acc_pkg::OFF_SC2, 32'h0000_0000, "sc2 reset");
        chk("hresp", 32'h0, hresp);
        wr(acc_pkg::OFF_SC1, 32'h0000_0043);
        rchk(acc_pkg::OFF_SC2, 32'h0000_0080, "active");
        wait_conv();
        chk("irq done", 32'h1, irq);
        rchk(acc_pkg::OFF_SC1, 32'h0000_00C3, "done set");
        chk("power idle", 32'h0, core_req.power);
        rchk(acc_pkg::OFF_SC2, 32'h0000_0000, "inactive");
        rchk(acc_pkg::OFF_RES_HI, 32'h0000_000A, "res hi");
        rchk(acc_pkg::OFF_RES_LO, 32'h0000_00BC, "res lo");
        rchk(acc_pkg::OFF_SC1, 32'h0000_0043, "lo read clr");
        wr(acc_pkg::OFF_SC1, 32'h0000_0003);
        wait_conv();
        wr(acc_pkg::OFF_SC1, 32'h0000_009F);
        rchk(acc_pkg::OFF_SC1, 32'h0000_001F, "bus no set");
        chk("isolate off", 32'h1, core_req.isolate);
        wr(acc_pkg::OFF_SC2, 32'h0000_0020);
        wr(acc_pkg::OFF_CMP_VAL, 32'h0000_0100);
        res_val = 12'h200;
        wr(acc_pkg::OFF_SC1, 32'h0000_0003);
        wait_conv();
        rchk(acc_pkg::OFF_SC1, 32'h0000_0003, "cmp false");
        rchk(acc_pkg::OFF_RES_LO, 32'h0000_00BC, "res held");
        res_val = 12'h050;
        wr(acc_pkg::OFF_SC1, 32'h0000_0003);
        wait_conv();
        rchk(acc_pkg::OFF_SC1, 32'h0000_0083, "cmp lt");
        rchk(acc_pkg::OFF_RES_LO, 32'h0000_0050, "res cmp");
        wr(acc_pkg::OFF_SC2, 32'h0000_0030);
        res_val = 12'h100;
        wr(acc_pkg::OFF_SC1, 32'h0000_0003);
        wait_conv();
        rchk(acc_pkg::OFF_SC1, 32'h0000_0083, "cmp ge");
        wr(acc_pkg::OFF_SC2, 32'h0000_0000);
        lat = 8'h04;
        snap = starts;
        wr(acc_pkg::OFF_SC1, 32'h0000_0025);
        repeat (40) @(posedge clk);
        chk("cont runs", 32'h1, 32'(starts - snap > 3));
        wr(acc_pkg::OFF_SC1, 32'h0000_003F);
        @(posedge clk);
        snap = starts;
        repeat (40) @(posedge clk);
        chk("cont stop", 32'(snap), 32'(starts));
        chk("power off", 32'h0, core_req.power);
        wr(acc_pkg::OFF_SC2, 32'h0000_0040);
        wr(acc_pkg::OFF_SC1, 32'h0000_0007);
        snap = starts;
        repeat (10) @(posedge clk);
        chk("no sw start", 32'(snap), 32'(starts));
        pin <= 1'b1;
        repeat (3) @(posedge clk);
        pin <= 1'b0;
        repeat (30) @(posedge clk);
        chk("hw single", 32'(snap + 1), 32'(starts));
        wr(acc_pkg::OFF_IRQ_MSK, 32'h0000_0001);
        chk("irq mask", 32'h1, irq);
        wr(acc_pkg::OFF_IRQ_STS, 32'h0000_0003);
        chk("irq w1c", 32'h0, irq);
        rchk(acc_pkg::OFF_IRQ_MSK, 32'h0000_0001, "mask rd");
        rchk(8'h1C, 32'h0000_0000, "unmapped");
        wr(acc_pkg::OFF_SC2, 32'h0000_0000);
        for (i = 0; i < 31; i++) begin
            wr(acc_pkg::OFF_SC1, 32'(i));
            chk("channel", 32'(i), 32'(core_req.channel));
        end
        wait_conv();
        rchk(acc_pkg::OFF_IRQ_STS, 32'h0000_0003, "abort sts");
        chk("irq sts", 32'h1, irq);
        rchk(acc_pkg::OFF_SC2, 32'h0000_0000, "idle after");
        tally_and_finish();
    end
endmodule // acc_ctrl_tb
`default_nettype wire
